//--- verilog/pwm_cfg.svh
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
// register byte offsets
`define OFS_PERIOD 6'h00
`define OFS_DEAD_TIME 6'h04
`define OFS_PULSE_DEL 6'h08
`define OFS_SYNC_WIDTH 6'h0c
`define OFS_DUTY_A 6'h10
`define OFS_DUTY_B 6'h14
`define OFS_DUTY_C 6'h18
`define OFS_SEGMENT 6'h1c
`define OFS_GATE 6'h20
`define OFS_MODE 6'h24
`define OFS_SW_SHUTDOWN 6'h28
`define OFS_STATUS 6'h2c
// field positions
`define SEG_ENABLE_LSB 0
`define SEG_CROSS_LSB 6
`define GATE_HIGH_EN_BIT 8
`define GATE_LOW_EN_BIT 9
`define MODE_DOUBLE_BIT 6
`define STAT_TRIP_BIT 0
`define STAT_SHUT_BIT 1
`define STAT_HALF_BIT 3
// reset values
`define RST_PERIOD 16'h0000
`define RST_DEAD_TIME 10'h000
`define RST_PULSE_DEL 10'h000
`define RST_SYNC_WIDTH 8'h27
`define RST_DUTY 16'h0000
`define RST_SEGMENT 9'h03f
`define RST_GATE 10'h000
`define RST_MODE 16'h0000
`endif

//--- verilog/pwm_pkg.sv
package pwm_pkg;
   typedef struct packed {
      logic [15:0] period;
      logic [9:0] dead_time;
      logic [9:0] pulse_del;
      logic [7:0] sync_width;
      logic [2:0][15:0] duty;
      logic [8:0] segment;
   } timing_set_type;
   typedef enum logic {first_half, second_half} half_type;
endpackage

//--- verilog/three_phase_pwm_controller.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ns
`include "pwm_cfg.svh"
// Overview of operation
// - six active-high gate outputs, one high and one low per phase
// - period, dead time, pulse deletion each from own register
// - one duty register per phase sets that pair's duty
// - each output has its own enable bit in the segment register
// - crossover bit per phase swaps high and low waveforms
// - 8-bit gate value sets chopping rate, chop mixed into outputs
// - separate chopping enables for high side and low side
// - single update mode loads new values once per period
// - double update mode also loads new values at midpoint
// - one mode register bit selects single or double update
// - sync pulse at the start of every period
// - double update mode adds a sync pulse at midpoint
// - sync pulse width set by the sync width register
// - trip pin low forces all outputs low without any clock
// - writing software shutdown register shuts all outputs down
// - status register shows trip level and period half
// - center-based complementary pairs with dead time before turn-on
// - shutdown from trip or software resets the timing unit
// - logic runs at the instruction rate clock
// - interrupt pulses on each sync pulse and on shutdown
// - period value counts clock ticks in half a period
// - dead time is value times two clock periods, zero gives none
// - sync pulse lasts width value plus one clocks, reset 0x27
// - in double mode status bit 3 shows second half
module three_phase_pwm_controller (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic trip_n_i,
   output logic phase_a_high_out_o,
   output logic phase_a_low_out_o,
   output logic phase_b_high_out_o,
   output logic phase_b_low_out_o,
   output logic phase_c_high_out_o,
   output logic phase_c_low_out_o,
   output logic sync_pulse_o,
   output logic sync_irq_o,
   output logic shutdown_irq_o
);
   pwm_pkg::timing_set_type soft_reg;
   pwm_pkg::timing_set_type act_reg;
   logic [9:0] gate_chopping_reg;
   logic [15:0] mode_control_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic trip_s1_reg;
   logic trip_s2_reg;
   logic shutdown_reg;
   logic [15:0] cnt_reg;
   pwm_pkg::half_type half_reg;
   logic sync_reg;
   logic [7:0] sync_cnt_reg;
   logic sync_irq_reg;
   logic shut_irq_reg;
   logic [7:0] chop_cnt_reg;
   logic chop_reg;
   logic [5:0] gate_reg;
   logic [2:0] raw_reg;
   logic [2:0][10:0] dt_cnt_reg;

   // bus decode
   wire take_w = (avs_read_i | avs_write_i) & wait_reg;
   wire done_w = (avs_read_i | avs_write_i) & ~wait_reg;
   wire wr_w = avs_write_i & ~wait_reg;
   wire [31:0] wd_w = avs_writedata_i;
   wire double_w = mode_control_reg[`MODE_DOUBLE_BIT];
   wire [15:0] status_w = {12'h000, double_w & (half_reg == pwm_pkg::second_half), 1'b0,
                           shutdown_reg, trip_s2_reg};
   logic [31:0] rd_mux;
   always_comb begin
      unique case (avs_address_i)
         `OFS_PERIOD: rd_mux = {16'h0000, soft_reg.period};
         `OFS_DEAD_TIME: rd_mux = {22'h000000, soft_reg.dead_time};
         `OFS_PULSE_DEL: rd_mux = {22'h000000, soft_reg.pulse_del};
         `OFS_SYNC_WIDTH: rd_mux = {24'h000000, soft_reg.sync_width};
         `OFS_DUTY_A: rd_mux = {16'h0000, soft_reg.duty[0]};
         `OFS_DUTY_B: rd_mux = {16'h0000, soft_reg.duty[1]};
         `OFS_DUTY_C: rd_mux = {16'h0000, soft_reg.duty[2]};
         `OFS_SEGMENT: rd_mux = {23'h000000, soft_reg.segment};
         `OFS_GATE: rd_mux = {22'h000000, gate_chopping_reg};
         `OFS_MODE: rd_mux = {16'h0000, mode_control_reg};
         `OFS_STATUS: rd_mux = {16'h0000, status_w};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= ~take_w;
         if (take_w) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         soft_reg <= {`RST_PERIOD, `RST_DEAD_TIME, `RST_PULSE_DEL, `RST_SYNC_WIDTH,
                      `RST_DUTY, `RST_DUTY, `RST_DUTY, `RST_SEGMENT};
         gate_chopping_reg <= `RST_GATE;
         mode_control_reg <= `RST_MODE;
      end else if (wr_w) begin
         unique case (avs_address_i)
            `OFS_PERIOD: soft_reg.period <= wd_w[15:0];
            `OFS_DEAD_TIME: soft_reg.dead_time <= wd_w[9:0];
            `OFS_PULSE_DEL: soft_reg.pulse_del <= wd_w[9:0];
            `OFS_SYNC_WIDTH: soft_reg.sync_width <= wd_w[7:0];
            `OFS_DUTY_A: soft_reg.duty[0] <= wd_w[15:0];
            `OFS_DUTY_B: soft_reg.duty[1] <= wd_w[15:0];
            `OFS_DUTY_C: soft_reg.duty[2] <= wd_w[15:0];
            `OFS_SEGMENT: soft_reg.segment <= wd_w[8:0];
            `OFS_GATE: gate_chopping_reg <= wd_w[9:0];
            `OFS_MODE: mode_control_reg <= wd_w[15:0];
            default: ;
         endcase
      end
   end

   // trip pin synchroniser for status and shutdown latch
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         trip_s1_reg <= 1'b1;
         trip_s2_reg <= 1'b1;
      end else begin
         trip_s1_reg <= trip_n_i;
         trip_s2_reg <= trip_s1_reg;
      end
   end

   wire sw_shut_w = wr_w & (avs_address_i == `OFS_SW_SHUTDOWN);
   wire shut_set_w = sw_shut_w | ~trip_s2_reg;
   wire shut_clr_w = wr_w & (avs_address_i == `OFS_STATUS);
   // both sources latch shutdown, set wins over clear
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         shutdown_reg <= 1'b0;
         shut_irq_reg <= 1'b0;
      end else begin
         shutdown_reg <= shut_set_w | (shutdown_reg & ~shut_clr_w);
         shut_irq_reg <= shut_set_w & ~shutdown_reg;
      end
   end

   // half period counter, up then down
   wire [16:0] cnt_inc_w = {1'b0, cnt_reg} + 17'h00001;
   wire mid_w = (half_reg == pwm_pkg::first_half) & (cnt_inc_w >= {1'b0, act_reg.period});
   wire start_w = (half_reg == pwm_pkg::second_half) & (cnt_reg == 16'h0000);
   wire load_w = start_w | (mid_w & double_w);
   wire sync_evt_w = start_w | (mid_w & double_w);
   always_ff @(posedge core_clk_i) begin
      // shutdown holds timing unit in its initial state
      if (!rstn_i || shutdown_reg) begin
         cnt_reg <= 16'h0000;
         half_reg <= pwm_pkg::first_half;
         act_reg <= soft_reg;
      end else begin
         if (load_w) begin
            act_reg <= soft_reg;
         end
         if (mid_w) begin
            half_reg <= pwm_pkg::second_half;
         end else if (start_w) begin
            half_reg <= pwm_pkg::first_half;
         end else if (half_reg == pwm_pkg::first_half) begin
            cnt_reg <= cnt_inc_w[15:0];
         end else begin
            cnt_reg <= cnt_reg - 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || shutdown_reg) begin
         sync_reg <= 1'b0;
         sync_cnt_reg <= 8'h00;
         sync_irq_reg <= 1'b0;
      end else begin
         sync_irq_reg <= sync_evt_w;
         if (sync_evt_w) begin
            sync_reg <= 1'b1;
            sync_cnt_reg <= act_reg.sync_width;
         end else if (sync_cnt_reg != 8'h00) begin
            sync_cnt_reg <= sync_cnt_reg - 8'h01;
         end else begin
            sync_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         chop_cnt_reg <= 8'h00;
         chop_reg <= 1'b0;
      end else if (chop_cnt_reg >= gate_chopping_reg[7:0]) begin
         chop_cnt_reg <= 8'h00;
         chop_reg <= ~chop_reg;
      end else begin
         chop_cnt_reg <= chop_cnt_reg + 8'h01;
      end
   end

   wire [10:0] dt_need_w = {act_reg.dead_time, 1'b0};
   wire [16:0] pd_w = {7'h00, act_reg.pulse_del};
   wire chop_hi_w = ~gate_chopping_reg[`GATE_HIGH_EN_BIT] | chop_reg;
   wire chop_lo_w = ~gate_chopping_reg[`GATE_LOW_EN_BIT] | chop_reg;
   logic [5:0] gate_next;
   genvar ph;
   generate
      for (ph = 0; ph < 3; ph = ph + 1) begin : g_phase
         wire [16:0] duty_w = {1'b0, act_reg.duty[ph]};
         wire [16:0] per_w = {1'b0, act_reg.period};
         wire [16:0] off_w = (duty_w >= per_w) ? 17'h00000 : per_w - duty_w;
         // pulse deletion of narrow on or off times
         wire del_on_w = duty_w < pd_w;
         wire full_on_w = off_w < pd_w;
         wire raw_w = ~del_on_w & (full_on_w | ({1'b0, cnt_reg} >= off_w));
         // dead time of twice the value before turn-on
         wire dt_ok_w = dt_cnt_reg[ph] >= dt_need_w;
         wire hi_w = raw_reg[ph] & dt_ok_w;
         wire lo_w = ~raw_reg[ph] & dt_ok_w & ~shutdown_reg;
         wire cross_w = act_reg.segment[`SEG_CROSS_LSB + ph];
         wire hsel_w = cross_w ? lo_w : hi_w;
         wire lsel_w = cross_w ? hi_w : lo_w;
         always_ff @(posedge core_clk_i) begin
            if (!rstn_i || shutdown_reg) begin
               raw_reg[ph] <= 1'b0;
               dt_cnt_reg[ph] <= 11'h000;
            end else begin
               raw_reg[ph] <= raw_w;
               if (raw_w != raw_reg[ph]) begin
                  dt_cnt_reg[ph] <= 11'h000;
               end else if (!dt_ok_w) begin
                  dt_cnt_reg[ph] <= dt_cnt_reg[ph] + 11'h001;
               end
            end
         end
         assign gate_next[2*ph] = hsel_w & act_reg.segment[`SEG_ENABLE_LSB + 2*ph] & chop_hi_w;
         assign gate_next[2*ph+1] = lsel_w & act_reg.segment[`SEG_ENABLE_LSB + 2*ph+1] & chop_lo_w;
      end
   endgenerate

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || shutdown_reg || shut_set_w) begin
         gate_reg <= 6'h00;
      end else begin
         gate_reg <= gate_next;
      end
   end

   assign phase_a_high_out_o = gate_reg[0] & trip_n_i;
   assign phase_a_low_out_o = gate_reg[1] & trip_n_i;
   assign phase_b_high_out_o = gate_reg[2] & trip_n_i;
   assign phase_b_low_out_o = gate_reg[3] & trip_n_i;
   assign phase_c_high_out_o = gate_reg[4] & trip_n_i;
   assign phase_c_low_out_o = gate_reg[5] & trip_n_i;
   assign sync_pulse_o = sync_reg;
   assign sync_irq_o = sync_irq_reg;
   assign shutdown_irq_o = shut_irq_reg;
   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence sync_start_s;
      sync_evt_w && act_reg.sync_width == 8'h00;
   endsequence
   bus_answer_a: assert property (take_w |=> !avs_waitrequest_o)
      else $error("waitrequest not released");
   trip_force_a: assert property (!trip_n_i |-> !phase_a_high_out_o && !phase_a_low_out_o
      && !phase_b_high_out_o && !phase_b_low_out_o && !phase_c_high_out_o
      && !phase_c_low_out_o)
      else $error("output high during trip");
   sw_shutdown_a: assert property (sw_shut_w |=> shutdown_reg ##1 gate_reg == 6'h00)
      else $error("software shutdown ignored");
   timing_reset_a: assert property (shutdown_reg |=> cnt_reg == 16'h0000)
      else $error("timing unit not reset");
   sync_width_a: assert property (sync_start_s |=> sync_reg ##1 !sync_reg)
      else $error("sync width wrong");
   sync_start_a: assert property (start_w && !shutdown_reg |=> sync_reg && sync_irq_o)
      else $error("no sync at period start");
   mid_sync_a: assert property (mid_w && double_w && !shutdown_reg |=> sync_irq_o)
      else $error("no midpoint sync");
   single_mid_a: assert property (mid_w && !double_w && !start_w |=> !sync_irq_o)
      else $error("midpoint sync in single mode");
   half_flag_a: assert property (double_w && half_reg == pwm_pkg::second_half
      |-> status_w[3])
      else $error("half flag wrong");
   no_overlap_a: assert property (!(gate_reg[0] && gate_reg[1])
      && !(gate_reg[2] && gate_reg[3]) && !(gate_reg[4] && gate_reg[5]))
      else $error("pair overlap");
endmodule

//--- tb/gate_driver_model.sv
`timescale 1ns/1ns
module gate_driver_model (
   input wire logic core_clk_i,
   input wire logic clear_i,
   input wire logic [5:0] gate_i,
   output logic [5:0][15:0] on_count_o,
   output logic [15:0] overlap_o
);
   // on-time per switch, both switches of a leg on counts as overlap
   always_ff @(posedge core_clk_i) begin
      for (int k = 0; k < 6; k++) begin
         if (clear_i)
            on_count_o[k] <= 16'h0000;
         else
            on_count_o[k] <= on_count_o[k] + 16'(gate_i[k]);
      end
      if (clear_i)
         overlap_o <= 16'h0000;
      else
         overlap_o <= overlap_o + 16'(|(gate_i & {gate_i[4], gate_i[5], gate_i[2],
            gate_i[3], gate_i[0], gate_i[1]}));
   end
endmodule

//--- tb/three_phase_pwm_controller_tb_top.sv
`timescale 1ns/1ns
`include "pwm_cfg.svh"
module three_phase_pwm_controller_tb_top;
   logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, trip_n = 1'b1, clr = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h00000000, rdata, rv;
   logic waitreq, sync, sync_irq, sd_irq;
   logic [5:0] g;
   logic [5:0][15:0] cnt;
   logic [15:0] ovl;
   int bad_count = 0, n_checks = 0, cycles = 0, sd_n = 0, w, gap;
   three_phase_pwm_controller three_phase_pwm_controller_inst (.core_clk_i(clk), .rstn_i(rstn),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .trip_n_i(trip_n),
      .phase_a_high_out_o(g[0]), .phase_a_low_out_o(g[1]), .phase_b_high_out_o(g[2]),
      .phase_b_low_out_o(g[3]), .phase_c_high_out_o(g[4]), .phase_c_low_out_o(g[5]),
      .sync_pulse_o(sync), .sync_irq_o(sync_irq), .shutdown_irq_o(sd_irq));
   gate_driver_model gate_driver_model_inst (.core_clk_i(clk), .clear_i(clr), .gate_i(g),
      .on_count_o(cnt), .overlap_o(ovl));
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (sd_irq === 1'b1)
         sd_n <= sd_n + 1;
      if (cycles == 20000) begin
         bad_count = bad_count + 1;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input logic is_wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= is_wr;
      rd <= ~is_wr;
      @(posedge clk);
      while (waitreq !== 1'b0) begin
         @(posedge clk);
      end
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task measure();
      repeat (40) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (32) @(posedge clk);
      @(negedge clk);
      check(ovl, 0);
   endtask
   task legs(input int ha, input int hb, input int hc, input int la);
      check(cnt[0], ha);
      check(cnt[2], hb);
      check(cnt[4], hc);
      check(cnt[1], la);
   endtask
   task sync_gap();
      int n;
      n = 0;
      @(negedge clk);
      while (sync !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      while (sync !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      check(sync_irq, 1);
      w = 0;
      while (sync === 1'b1 && n < 200) begin
         @(negedge clk);
         w++;
         n++;
      end
      gap = w;
      while (sync !== 1'b1 && n < 200) begin
         @(negedge clk);
         gap++;
         n++;
      end
   endtask
   task test_reset();
      bus(0, `OFS_SYNC_WIDTH, 0);
      check(rv, 32'h00000027);
      bus(0, `OFS_SEGMENT, 0);
      check(rv, 32'h0000003f);
      bus(0, 6'h30, 0);
      check(rv, 32'h00000000);
   endtask
   task test_duty();
      bus(1, `OFS_PERIOD, 32'h00000008);
      bus(1, `OFS_SYNC_WIDTH, 32'h00000002);
      bus(1, `OFS_DUTY_A, 32'h00000004);
      bus(1, `OFS_DUTY_B, 32'h00000002);
      bus(1, `OFS_DUTY_C, 32'h00000006);
      measure();
      legs(16, 8, 24, 16);
      bus(1, `OFS_DEAD_TIME, 32'h00000001);
      measure();
      legs(12, 4, 20, 12);
      bus(1, `OFS_DEAD_TIME, 32'h00000000);
   endtask
   task test_outputs();
      bus(1, `OFS_SEGMENT, 32'h0000007e);
      measure();
      check(cnt[0], 0);
      check(cnt[1], 16);
      check(cnt[2], 8);
      bus(1, `OFS_SEGMENT, 32'h0000003f);
      bus(1, `OFS_GATE, 32'h00000101);
      measure();
      legs(8, 4, 12, 16);
      bus(1, `OFS_GATE, 32'h00000201);
      measure();
      check(cnt[0], 16);
      check(cnt[1], 8);
      bus(1, `OFS_GATE, 32'h00000000);
      bus(1, `OFS_PULSE_DEL, 32'h00000003);
      measure();
      check(cnt[2], 0);
      check(cnt[0], 16);
      bus(1, `OFS_PULSE_DEL, 32'h00000000);
   endtask
   task test_sync(input logic dbl);
      int hi, lo;
      hi = 0;
      lo = 1;
      bus(1, `OFS_MODE, {25'h0, dbl, 6'h00});
      repeat (40) @(posedge clk);
      sync_gap();
      check(w, 3);
      check(gap, dbl ? 8 : 16);
      for (int k = 0; k < 12; k++) begin
         bus(0, `OFS_STATUS, 0);
         hi = hi | rv[`STAT_HALF_BIT];
         lo = lo & rv[`STAT_HALF_BIT];
      end
      check({hi[0], lo[0]}, dbl ? 2'b10 : 2'b00);
      check(gap, dbl ? 8 : 16);
   endtask
   task test_trip();
      int s;
      s = sd_n;
      @(posedge clk);
      trip_n <= 1'b0;
      #1;
      check(g, 6'h00);
      repeat (4) @(posedge clk);
      bus(0, `OFS_STATUS, 0);
      check(rv[1:0], 2'b10);
      check(sd_n, s + 1);
      trip_n <= 1'b1;
      repeat (4) @(posedge clk);
      bus(1, `OFS_STATUS, 0);
      measure();
      check(cnt[0], 16);
      bus(1, `OFS_SW_SHUTDOWN, 32'h00000001);
      repeat (3) @(posedge clk);
      #1;
      check(g, 6'h00);
      check(sd_n, s + 2);
      bus(0, `OFS_STATUS, 0);
      check(rv[1:0], 2'b11);
      bus(1, `OFS_STATUS, 0);
      measure();
      check(cnt[4], 24);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      test_reset();
      test_duty();
      test_outputs();
      test_sync(1'b0);
      test_sync(1'b1);
      test_trip();
      summarize();
   end
endmodule
